/* File: rtl/udc_pkg.sv */
/*
 * constants and types for the usb device control and status block.
 * assumes one 250 MHz clock shared with the serial engine and the cpu port.
 */
package udc_pkg;
   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [7:0] ADDR_CTRL = 8'h38;
   localparam logic [7:0] ADDR_STAT = 8'h39;
   localparam logic [7:0] ADDR_MASK = 8'h3A;
   localparam logic [7:0] ADDR_OPT = 8'h3B;
   localparam logic [7:0] ADDR_EP0D4 = 8'h43;
   localparam logic [7:0] ADDR_EP0D5 = 8'h44;
   localparam logic [7:0] ADDR_EP0D6 = 8'h45;
   localparam logic [7:0] ADDR_EP0D7 = 8'h46;
   // ****************************************
   // field positions
   // ****************************************
   localparam int NUM_EP = 5;
   localparam int NUM_FLAGS = 6;
   localparam int CTRL_RESUME = 5;
   localparam int CTRL_CLKGATE = 6;
   localparam int CTRL_ENABLE = 7;
   localparam int STAT_SUSP = 0;
   localparam int STAT_WAKE = 1;
   localparam int STAT_BRST = 2;
   localparam int STAT_CFGCHG = 3;
   localparam int STAT_SOF = 4;
   localparam int STAT_SETUP = 5;
   localparam int STAT_CONFIG = 7;
   localparam int OPT_RST_SEL = 0;
   // ****************************************
   // request decoding
   // ****************************************
   localparam logic [1:0] REQ_TYPE_STD = 2'h0;
   localparam logic [7:0] REQ_GET_DESC = 8'h06;
   localparam logic [7:0] REQ_SYNC_FRAME = 8'h0C;
   localparam logic [7:0] CFG_ONE = 8'h01;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 4;
   localparam int RESUME_MIN_NS = 3_000_000;
   localparam int IDLE_SUSP_NS = 3_000_000;
   // drive strictly longer than the minimum, hence the extra cycle
   localparam int RESUME_CYC = RESUME_MIN_NS / CLK_PERIOD_NS + 1;
   localparam int IDLE_CYC = IDLE_SUSP_NS / CLK_PERIOD_NS;
   localparam int CNT_W = 20;
   // ****************************************
   // types
   // ****************************************
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } udc_bus_req_t;
   typedef struct packed {
      logic valid;
      logic [7:0] bm_req;
      logic [7:0] b_req;
      logic crc_err;
      logic tok_err;
      logic eop_err;
   } udc_setup_t;
   typedef enum logic [0:0] {
      RSM_IDLE = 1'b0,
      RSM_DRIVE = 1'b1
   } udc_rsm_t;
   typedef struct packed {
      logic enable;
      logic clk_gate;
      logic [NUM_EP-1:0] xfer_en;
      logic rst_sel;
      logic [NUM_FLAGS-1:0] flags;
      logic [NUM_FLAGS-1:0] mask;
      logic config_one;
      logic susp_mode;
      udc_rsm_t rsm;
      logic [CNT_W-1:0] rsm_cnt;
      logic [CNT_W-1:0] idle_cnt;
      logic [7:0] rdata;
      logic irq;
      logic mcu_rst;
      logic load_cfg;
      logic [3:0][7:0] rx_buf;
      logic [3:0][7:0] tx_buf;
   } udc_state_t;
   localparam udc_state_t ST_RST = '0;
endpackage : udc_pkg

/* File: rtl/udc_ctrl.sv */
/*
 * usb device control and status registers, suspend and remote wakeup timing,
 * bus reset routing and the upper endpoint 0 data bytes.
 * assumes the serial engine runs on clk and gives one-cycle event pulses.
 */
`timescale 1ns/1ps
// Functional notes
// - enable rising loads endpoint configuration
// - enable clear resets module to powered
// - clock gate bit passes module clock
// - per endpoint transfer done interrupt enables
// - resume write drives K when suspended
// - resume signalling held longer than 3ms
// - resume bit reads zero, zero ignored
// - config bit shows configuration one
// - setup flag for software handled requests
// - setup flag only on error free
// - flags clear by zero, one ignored
// - sof flag on start of frame
// - config change flag on accepted request
// - bus reset flag on reset state
// - bus reset: chip reset or interrupt
// - wake flag on activity while suspended
// - suspend flag on state or idle
// - ep0 bytes: read out, write in
// - mask bit per flag enables interrupt
// - bus reset irq needs flag, select, mask
module udc_ctrl import udc_pkg::*; #(
   parameter int RESUME_CYCLES = RESUME_CYC,
   parameter int IDLE_CYCLES = IDLE_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   input wire udc_bus_req_t bus,
   output logic [7:0] rdata,
   input wire udc_setup_t setup,
   input wire logic sof_det,
   input wire logic cfg_req,
   input wire logic [7:0] cfg_value,
   input wire logic bus_reset_det,
   input wire logic bus_activity,
   input wire logic suspend_det,
   input wire logic remote_wake_en,
   input wire logic ep0_in_done,
   input wire logic ep0_out_done,
   input wire logic [NUM_EP-2:0] ep_done,
   input wire logic rx_wr,
   input wire logic [1:0] rx_idx,
   input wire logic [7:0] rx_byte,
   output logic [3:0][7:0] tx_bytes,
   output logic module_enable,
   output logic module_clock_gate,
   output logic usb_module_rst,
   output logic load_cfg,
   output logic resume_k_drive,
   output logic suspended,
   output logic config_num,
   output logic irq,
   output logic mcu_reset_req
);
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic is_ep0_byte(input logic [7:0] a);
      is_ep0_byte = (a >= ADDR_EP0D4) && (a <= ADDR_EP0D7);
   endfunction : is_ep0_byte

   function automatic logic [1:0] ep0_index(input logic [7:0] a);
      logic [7:0] d;
      d = a - ADDR_EP0D4;
      ep0_index = d[1:0];
   endfunction : ep0_index

   // requests the hardware leaves to software
   function automatic logic is_sw_req(input logic [7:0] bm, input logic [7:0] br);
      is_sw_req = (bm[6:5] != REQ_TYPE_STD) || (br == REQ_GET_DESC) || (br == REQ_SYNC_FRAME);
   endfunction : is_sw_req

   localparam logic [CNT_W-1:0] RSM_LAST = CNT_W'(RESUME_CYCLES - 1);
   localparam logic [CNT_W-1:0] IDLE_LAST = CNT_W'(IDLE_CYCLES - 1);

   udc_state_t st_reg;
   udc_state_t st_next;
   logic resume_go;
   logic setup_ok;
   logic idle_hit;
   logic cfg_ok;
   logic [NUM_FLAGS-1:0] set_vec;
   logic [NUM_EP-1:0] done_vec;
   logic irq_src;

   // ****************************************
   // event qualification
   // ****************************************
   assign done_vec = {ep_done, ep0_in_done | ep0_out_done};
   assign setup_ok = setup.valid && !setup.crc_err && !setup.tok_err && !setup.eop_err
                     && is_sw_req(setup.bm_req, setup.b_req);
   assign idle_hit = st_reg.enable && !st_reg.susp_mode && !bus_activity && (st_reg.idle_cnt == IDLE_LAST);
   assign cfg_ok = cfg_req && (cfg_value <= CFG_ONE);
   assign resume_go = bus.wr && (bus.addr == ADDR_CTRL) && bus.wdata[CTRL_RESUME]
                      && st_reg.enable && st_reg.susp_mode && remote_wake_en && (st_reg.rsm == RSM_IDLE);

   always_comb begin
      set_vec = '0;
      if (st_reg.enable) begin
         set_vec[STAT_SETUP] = setup_ok;
         set_vec[STAT_SOF] = sof_det;
         set_vec[STAT_CFGCHG] = cfg_ok;
         set_vec[STAT_BRST] = bus_reset_det;
         set_vec[STAT_WAKE] = st_reg.susp_mode && bus_activity;
         set_vec[STAT_SUSP] = !st_reg.susp_mode && (suspend_det || idle_hit);
      end
   end

   // bus reset only reaches the line when routed to interrupt
   assign irq_src = (|(st_reg.flags & st_reg.mask & ~(NUM_FLAGS'(1) << STAT_BRST)))
                    || (st_reg.flags[STAT_BRST] && st_reg.mask[STAT_BRST] && st_reg.rst_sel)
                    || (|(st_reg.xfer_en & done_vec));

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      st_next = st_reg;
      st_next.load_cfg = 1'b0;
      st_next.mcu_rst = 1'b0;
      st_next.rdata = 8'h00;
      if (bus.wr) begin
         case (bus.addr)
            ADDR_CTRL: begin
               st_next.xfer_en = bus.wdata[NUM_EP-1:0];
               st_next.clk_gate = bus.wdata[CTRL_CLKGATE];
               st_next.enable = bus.wdata[CTRL_ENABLE];
            end
            ADDR_STAT: st_next.flags = st_reg.flags & bus.wdata[NUM_FLAGS-1:0];
            ADDR_MASK: st_next.mask = bus.wdata[NUM_FLAGS-1:0];
            ADDR_OPT: st_next.rst_sel = bus.wdata[OPT_RST_SEL];
            default: begin
               if (is_ep0_byte(bus.addr)) begin
                  st_next.tx_buf[ep0_index(bus.addr)] = bus.wdata;
               end
            end
         endcase
      end
      // hardware sets win over a clearing write in the same cycle
      st_next.flags = st_next.flags | set_vec;
      st_next.load_cfg = st_next.enable && !st_reg.enable;
      if (set_vec[STAT_SUSP]) begin
         st_next.susp_mode = 1'b1;
      end
      if (set_vec[STAT_WAKE]) begin
         st_next.susp_mode = 1'b0;
      end
      if (st_reg.enable && cfg_ok) begin
         st_next.config_one = (cfg_value == CFG_ONE);
      end
      if (set_vec[STAT_BRST]) begin
         st_next.config_one = 1'b0;
         st_next.susp_mode = 1'b0;
         st_next.mcu_rst = !st_reg.rst_sel;
      end
      // idle watch: any activity or suspension restarts the count
      if (!st_reg.enable || st_reg.susp_mode || bus_activity || idle_hit) begin
         st_next.idle_cnt = '0;
      end else begin
         st_next.idle_cnt = st_reg.idle_cnt + 1'b1;
      end
      case (st_reg.rsm)
         RSM_IDLE: begin
            if (resume_go) begin
               st_next.rsm = RSM_DRIVE;
               st_next.rsm_cnt = '0;
            end
         end
         RSM_DRIVE: begin
            if (st_reg.rsm_cnt == RSM_LAST) begin
               st_next.rsm = RSM_IDLE;
               st_next.susp_mode = 1'b0;
            end else begin
               st_next.rsm_cnt = st_reg.rsm_cnt + 1'b1;
            end
         end
         default: st_next.rsm = RSM_IDLE;
      endcase
      if (rx_wr) begin
         st_next.rx_buf[rx_idx] = rx_byte;
      end
      // disabled module is held in its powered state
      if (!st_reg.enable) begin
         st_next.susp_mode = 1'b0;
         st_next.config_one = 1'b0;
         st_next.rsm = RSM_IDLE;
         st_next.rsm_cnt = '0;
      end
      if (bus.rd) begin
         case (bus.addr)
            ADDR_CTRL: st_next.rdata = {st_reg.enable, st_reg.clk_gate, 1'b0, st_reg.xfer_en};
            ADDR_STAT: st_next.rdata = {st_reg.config_one, 1'b0, st_reg.flags};
            ADDR_MASK: st_next.rdata = {2'h0, st_reg.mask};
            ADDR_OPT: st_next.rdata = {7'h00, st_reg.rst_sel};
            default: begin
               if (is_ep0_byte(bus.addr)) begin
                  st_next.rdata = st_reg.rx_buf[ep0_index(bus.addr)];
               end
            end
         endcase
      end
      st_next.irq = irq_src;
      // data bytes keep their contents through reset
      if (!nrst) begin
         st_next = ST_RST;
         st_next.rx_buf = st_reg.rx_buf;
         st_next.tx_buf = st_reg.tx_buf;
      end
   end

   always_ff @(posedge clk) begin
      st_reg <= st_next;
   end

   // ****************************************
   // outputs
   // ****************************************
   assign rdata = st_reg.rdata;
   assign tx_bytes = st_reg.tx_buf;
   assign module_enable = st_reg.enable;
   assign module_clock_gate = st_reg.clk_gate;
   assign usb_module_rst = !st_reg.enable;
   assign load_cfg = st_reg.load_cfg;
   assign resume_k_drive = (st_reg.rsm == RSM_DRIVE);
   assign suspended = st_reg.susp_mode;
   assign config_num = st_reg.config_one;
   assign irq = st_reg.irq;
   assign mcu_reset_req = st_reg.mcu_rst;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence s_ctrl_write;
      bus.wr && (bus.addr == ADDR_CTRL);
   endsequence

   sequence s_resume_req;
      s_ctrl_write ##0 bus.wdata[CTRL_RESUME] ##0 suspended && remote_wake_en && !resume_k_drive;
   endsequence

   a_load_on_enable: assert property ($rose(module_enable) |-> load_cfg)
      else $error("enable rose without configuration load");
   a_disable_quiet: assert property (!module_enable |=> !suspended && !resume_k_drive)
      else $error("disabled module left suspended or resuming");
   a_clock_gate: assert property (s_ctrl_write |=> module_clock_gate == $past(bus.wdata[CTRL_CLKGATE]))
      else $error("clock gate does not follow write");
   a_resume_gate: assert property ($rose(resume_k_drive) |-> $past(suspended && remote_wake_en))
      else $error("resume driven while not allowed");
   a_resume_start: assert property (module_enable ##0 s_resume_req |=> resume_k_drive)
      else $error("allowed resume request not driven");
   // a disable also drops the drive early, which is not a timing fault
   a_resume_len: assert property ($fell(resume_k_drive) && $past(module_enable) |-> $past(st_reg.rsm_cnt) == RSM_LAST)
      else $error("resume released early or late");
   a_resume_reads_zero: assert property (bus.rd && bus.addr == ADDR_CTRL |=> !rdata[CTRL_RESUME])
      else $error("resume bit read as one");
   a_config_one: assert property (module_enable && cfg_req && cfg_value == CFG_ONE |=> config_num)
      else $error("configuration one not reported");
   a_setup_error: assert property (setup.valid && setup.crc_err && !st_reg.flags[STAT_SETUP] |=>
      !st_reg.flags[STAT_SETUP])
      else $error("setup flag set on bad packet");
   a_flag_clear: assert property (bus.wr && bus.addr == ADDR_STAT && !bus.wdata[STAT_SOF] && !sof_det |=>
      !st_reg.flags[STAT_SOF])
      else $error("sof flag not cleared by zero");
   a_sof_set: assert property (module_enable && sof_det |=> st_reg.flags[STAT_SOF])
      else $error("sof flag missed");
   a_brst_route: assert property (module_enable && bus_reset_det && !st_reg.rst_sel |=> mcu_reset_req)
      else $error("bus reset did not request chip reset");
   a_irq_cause: assert property (irq |-> $past(irq_src))
      else $error("interrupt without enabled source");
endmodule : udc_ctrl

/* File: test/udc_host_model.sv */
/*
 * host side model: drives the serial engine events (setup packets, frame
 * markers, configuration requests, bus reset, suspend, activity) into the block.
 * assumes it shares clk with the block and that the bench calls its tasks.
 */
`timescale 1ns/1ps
module udc_host_model import udc_pkg::*; (
   input wire logic clk,
   output udc_setup_t setup,
   output logic sof_det,
   output logic cfg_req,
   output logic [7:0] cfg_value,
   output logic bus_reset_det,
   output logic bus_activity,
   output logic suspend_det,
   output logic remote_wake_en
);
   initial begin
      setup = '0;
      sof_det = 1'b0;
      cfg_req = 1'b0;
      bus_reset_det = 1'b0;
      suspend_det = 1'b0;
      remote_wake_en = 1'b0;
      cfg_value = 8'h00;
      bus_activity = 1'b1;
   end
   // fields outside the valid cycle show the inverse, never a stale copy
   task automatic send_setup(input logic [7:0] bm, input logic [7:0] rq, input logic [2:0] err);
      @(posedge clk);
      setup <= {1'b1, bm, rq, err};
      @(posedge clk);
      setup <= {1'b0, ~bm, ~rq, ~err};
   endtask : send_setup
   // which: bus reset, suspend, start of frame
   task automatic pulse(input logic [2:0] which);
      @(posedge clk);
      bus_reset_det <= which[2];
      suspend_det <= which[1];
      sof_det <= which[0];
      @(posedge clk);
      bus_reset_det <= 1'b0;
      suspend_det <= 1'b0;
      sof_det <= 1'b0;
   endtask : pulse
   // level inputs: only this model drives them
   task automatic set_activity(input logic v);
      bus_activity <= v;
   endtask : set_activity
   task automatic set_wake(input logic v);
      remote_wake_en <= v;
   endtask : set_wake
   task automatic set_config(input logic [7:0] v);
      @(posedge clk);
      cfg_req <= 1'b1;
      cfg_value <= v;
      @(posedge clk);
      cfg_req <= 1'b0;
      cfg_value <= ~v;
   endtask : set_config
endmodule : udc_host_model

/* File: test/udc_ctrl_tb.sv */
/*
 * self-checking bench for the control and status block.
 * assumes the host model file is compiled first and short timing parameters.
 */
`timescale 1ns/1ps
module udc_ctrl_tb import udc_pkg::*; ;
   localparam int RSM = 20;
   localparam int IDL = 30;
   logic clk, nrst, sof_det, cfg_req, bus_reset_det, bus_activity, suspend_det, remote_wake_en;
   logic ep0_in_done, ep0_out_done, rx_wr, module_enable, module_clock_gate, usb_module_rst;
   logic load_cfg, resume_k_drive, suspended, config_num, irq, mcu_reset_req;
   logic [7:0] rdata, cfg_value, rx_byte, v;
   logic [1:0] rx_idx;
   logic [3:0] ep_done;
   logic [4:0] d;
   logic [3:0][7:0] tx_bytes;
   udc_bus_req_t bus;
   udc_setup_t setup;
   int errors, n_compared, cyc, n;
   // selectors into the watched single-bit outputs
   localparam int O_LOAD = 0;
   localparam int O_IRQ = 1;
   localparam int O_RSM = 2;
   localparam int O_SUSP = 3;
   logic [3:0] obs;
   assign obs = {suspended, resume_k_drive, irq, load_cfg};
   // request type, request code, {crc, token, eop} errors, flag expected
   logic [19:0] tab [8] = '{20'h0006_1, 20'h820C_1, 20'h0005_0, 20'h2109_1,
                            20'hC001_1, 20'h0006_2, 20'h0006_4, 20'h0006_8};
   udc_host_model u_udc_host_model (.clk(clk), .setup(setup), .sof_det(sof_det), .cfg_req(cfg_req),
      .cfg_value(cfg_value), .bus_reset_det(bus_reset_det), .bus_activity(bus_activity),
      .suspend_det(suspend_det), .remote_wake_en(remote_wake_en));
   udc_ctrl #(.RESUME_CYCLES(RSM), .IDLE_CYCLES(IDL)) u_udc_ctrl (.clk(clk), .nrst(nrst), .bus(bus),
      .rdata(rdata), .setup(setup), .sof_det(sof_det), .cfg_req(cfg_req), .cfg_value(cfg_value),
      .bus_reset_det(bus_reset_det), .bus_activity(bus_activity), .suspend_det(suspend_det),
      .remote_wake_en(remote_wake_en), .ep0_in_done(ep0_in_done), .ep0_out_done(ep0_out_done),
      .ep_done(ep_done), .rx_wr(rx_wr), .rx_idx(rx_idx), .rx_byte(rx_byte), .tx_bytes(tx_bytes),
      .module_enable(module_enable), .module_clock_gate(module_clock_gate),
      .usb_module_rst(usb_module_rst), .load_cfg(load_cfg), .resume_k_drive(resume_k_drive),
      .suspended(suspended), .config_num(config_num), .irq(irq), .mcu_reset_req(mcu_reset_req));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic final_report();
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : final_report
   // the run should need under 2000 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         errors++;
         final_report();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] dt);
      @(posedge clk);
      bus <= '{a, dt, 1'b1, 1'b0};
      @(posedge clk);
      bus <= '0;
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      bus <= '0;
      #1 chk(rdata, exp);
   endtask : rchk
   // the bit is read after the wait, not when the task is called
   task automatic bit_after(input int edges, input int sel, input logic exp);
      repeat (edges) @(posedge clk);
      #1 chk({7'h00, obs[sel]}, {7'h00, exp});
   endtask : bit_after
   task automatic count_rst();
      n = 0;
      repeat (4) begin
         #1 n += int'(mcu_reset_req === 1'b1);
         @(posedge clk);
      end
   endtask : count_rst
   initial begin
      bus = '0;
      nrst = 1'b0;
      ep0_in_done = 1'b0;
      ep0_out_done = 1'b0;
      ep_done = 4'h0;
      rx_wr = 1'b0;
      rx_idx = 2'h0;
      rx_byte = 8'h00;
      {errors, n_compared, cyc} = '0;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      rchk(ADDR_CTRL, 8'h00);
      rchk(ADDR_STAT, 8'h00);
      rchk(ADDR_MASK, 8'h00);
      rchk(8'h50, 8'h00);
      chk({7'h00, usb_module_rst}, 8'h01);
      $display("test reset finished");
      wr(ADDR_STAT, 8'h00);
      wr(ADDR_CTRL, 8'h40);
      #1 chk({6'h00, module_clock_gate, module_enable}, 8'h02);
      wr(ADDR_CTRL, 8'hC0);
      #1 chk({5'h00, load_cfg, module_enable, usb_module_rst}, 8'h06);
      bit_after(1, O_LOAD, 1'b0);
      wr(ADDR_CTRL, 8'hE0);
      bit_after(0, O_RSM, 1'b0);
      rchk(ADDR_CTRL, 8'hC0);
      $display("test enable finished");
      for (int i = 0; i < 8; i++) begin
         u_udc_host_model.send_setup(tab[i][19:12], tab[i][11:4], tab[i][3:1]);
         rchk(ADDR_STAT, {2'h0, tab[i][0], 5'h00});
         wr(ADDR_STAT, 8'h00);
      end
      u_udc_host_model.pulse(3'h1);
      bit_after(1, O_IRQ, 1'b0);
      wr(ADDR_STAT, 8'hFF);
      rchk(ADDR_STAT, 8'h10);
      wr(ADDR_MASK, 8'h10);
      bit_after(1, O_IRQ, 1'b1);
      wr(ADDR_STAT, 8'h00);
      bit_after(1, O_IRQ, 1'b0);
      u_udc_host_model.set_config(8'h01);
      rchk(ADDR_STAT, 8'h88);
      chk({7'h00, config_num}, 8'h01);
      wr(ADDR_STAT, 8'h00);
      u_udc_host_model.set_config(8'h02);
      rchk(ADDR_STAT, 8'h80);
      u_udc_host_model.set_config(8'h00);
      rchk(ADDR_STAT, 8'h08);
      $display("test flags finished");
      wr(ADDR_MASK, 8'h04);
      wr(ADDR_STAT, 8'h00);
      u_udc_host_model.pulse(3'h4);
      count_rst();
      chk(8'(n), 8'h01);
      rchk(ADDR_STAT, 8'h04);
      chk({7'h00, irq}, 8'h00);
      wr(ADDR_OPT, 8'h01);
      wr(ADDR_STAT, 8'h00);
      u_udc_host_model.pulse(3'h4);
      count_rst();
      chk({irq, 7'(n)}, 8'h80);
      wr(ADDR_MASK, 8'h00);
      bit_after(1, O_IRQ, 1'b0);
      wr(ADDR_STAT, 8'h00);
      $display("test bus reset finished");
      for (int i = 0; i < 5; i++) begin
         d = 5'h01 << i;
         ep_done <= d[4:1];
         ep0_in_done <= d[0];
         wr(ADDR_CTRL, 8'hC0 | {3'h0, ~d});
         bit_after(2, O_IRQ, 1'b0);
         wr(ADDR_CTRL, 8'hC0 | {3'h0, d});
         bit_after(2, O_IRQ, 1'b1);
      end
      ep0_in_done <= 1'b0;
      ep_done <= 4'h0;
      ep0_out_done <= 1'b1;
      wr(ADDR_CTRL, 8'hC1);
      bit_after(2, O_IRQ, 1'b1);
      ep0_out_done <= 1'b0;
      wr(ADDR_CTRL, 8'hC0);
      $display("test transfer enables finished");
      u_udc_host_model.set_activity(1'b0);
      n = 0;
      while (suspended !== 1'b1 && n < 60) begin
         @(posedge clk);
         #1 n++;
      end
      chk(8'(n), 8'(IDL));
      rchk(ADDR_STAT, 8'h01);
      u_udc_host_model.set_wake(1'b1);
      wr(ADDR_CTRL, 8'hE0);
      n = 0;
      #1;
      while (resume_k_drive === 1'b1 && n < 100) begin
         @(posedge clk);
         #1 n++;
      end
      chk(8'(n), 8'(RSM));
      chk({7'h00, suspended}, 8'h00);
      u_udc_host_model.set_activity(1'b1);
      wr(ADDR_STAT, 8'h00);
      u_udc_host_model.set_activity(1'b0);
      u_udc_host_model.pulse(3'h2);
      u_udc_host_model.set_activity(1'b1);
      bit_after(0, O_SUSP, 1'b1);
      bit_after(2, O_SUSP, 1'b0);
      rchk(ADDR_STAT, 8'h03);
      $display("test suspend finished");
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_EP0D4 + 8'(i), 8'hA0 + 8'(i));
         @(posedge clk);
         rx_wr <= 1'b1;
         rx_idx <= 2'(i);
         rx_byte <= 8'h50 + 8'(i);
         @(posedge clk);
         rx_wr <= 1'b0;
      end
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         #1 chk(tx_bytes[i], 8'hA0 + 8'(i));
         rchk(ADDR_EP0D4 + 8'(i), 8'h50 + 8'(i));
      end
      rchk(ADDR_CTRL, 8'h00);
      u_udc_host_model.pulse(3'h1);
      rchk(ADDR_STAT, 8'h00);
      $display("test data bytes finished");
      final_report();
   end
endmodule : udc_ctrl_tb
